/* File: hw/pdsir_pkg.sv */
// Purpose: constants for the per-port diagnostic, status and event registers
// Assumes: 16-bit register words, port number in address bits 15:12
// Notes: offsets are port-relative; the port number is added above them
`default_nettype none
package pdsir_pkg;
	// =========================================================
	// address map
	localparam logic [3:0]  PORT_SHIFT_W      = 4'hC;
	localparam logic [11:0] OFS_CABLE_DIAG    = 12'h124;
	localparam logic [11:0] OFS_LINK_STATUS   = 12'h126;
	localparam logic [11:0] OFS_RX_SYM_ERR    = 12'h12A;
	localparam logic [11:0] OFS_EVENT_CTRL    = 12'h136;
	// =========================================================
	// cable diagnostic control fields
	localparam int          DIAG_TRIG_BIT     = 15;
	localparam int          DIAG_RSV14_BIT    = 14;
	localparam int          DIAG_PAIR_LSB     = 12;
	localparam int          DIAG_RSV_LSB      = 10;
	localparam int          DIAG_RESULT_LSB   = 8;
	localparam logic [1:0]  PAIR_RESET        = 2'h0;
	localparam logic [1:0]  RESULT_RESET      = 2'h0;
	localparam logic [1:0]  RESULT_OPEN       = 2'h1;
	localparam logic [1:0]  RESULT_SHORT      = 2'h2;
	// =========================================================
	// link status and event register fields
	localparam int          LINK_GIG_BIT      = 1;
	localparam int          LINK_FAST_BIT     = 0;
	localparam int          EVENT_EN_LSB      = 8;
	localparam int          EVENT_FLAG_LSB    = 0;
	localparam logic [7:0]  EVENT_RESET       = 8'h00;
	localparam logic [15:0] COUNT_RESET       = 16'h0000;
	localparam logic [15:0] COUNT_MAX         = 16'hFFFF;
	// =========================================================
	// diagnostic sequencer states
	typedef enum logic [0:0]
	{
		DIAG_IDLE = 1'b0,
		DIAG_RUN  = 1'b1
	} pdsir_diag_t;
endpackage
`default_nettype wire

/* File: hw/pdsir_port_regs.sv */
// Purpose: one transceiver port's diagnostic, link, error count and events
// Assumes: all inputs come from logic on the same clock
// Notes: one instance per port; PORT_NUM selects the 0xN000 address page
// Summary of operation
// R1 - a one written to the trigger bit starts a test that clears it when done.
// R2 - a zero written to the trigger bit starts no test.
// R3 - the trigger bit reads one while a test runs and zero once done.
// R4 - bits 13:12 pick pair A to D for the test and reset to pair A.
// R5 - bits 9:8 report no fault, open or short and reset to no fault.
// R6 - status bit 1 shows whether the gigabit link is up.
// R7 - status bit 0 shows whether the fast link is up.
// R8 - a 16-bit count of symbol-error frames resets to zero and clears on read.
// R9 - bits 15:8 of the event register are read-write source enables.
// R10 - bits 7:0 are read-only flags, each eight places below its enable.
// R11 - a flag sets on its event and stays set until a register read clears it.
// R12 - all enables and flags reset to zero.
// R13 - the interrupt request is high while any set flag has its enable set.
// R14 - flags record events whatever their enable holds.
`default_nettype none
module pdsir_port_regs
	import pdsir_pkg::*;
#(
	parameter logic [3:0] PORT_NUM = 4'h1
)
(
	input  wire logic        clock,       // system clock
	input  wire logic        rst,         // async reset, active high
	input  wire logic [15:0] regAddr,     // absolute register address
	input  wire logic        regWr,       // write strobe, one cycle
	input  wire logic        regRd,       // read strobe, one cycle
	input  wire logic [15:0] regWdata,    // write data
	output logic      [15:0] regRdata,    // read data, one cycle after regRd
	output logic             regRdValid,  // read data valid pulse
	output logic             diagStart,   // pulse: begin measurement
	output logic      [1:0]  diagPair,    // pair under test
	input  wire logic        diagDone,    // pulse: measurement over
	input  wire logic [1:0]  diagResult,  // fault code with diagDone
	input  wire logic        gigLinkUp,   // gigabit link level
	input  wire logic        fastLinkUp,  // fast link level
	input  wire logic        symErrFrame, // pulse: frame with symbol error
	input  wire logic [7:0]  eventIn,     // event pulses, jabber at bit 7
	output logic             irqReq       // per-port interrupt request
);
	// =========================================================
	// decode
	logic hitPage;
	logic wrDiag;
	logic wrEvt;
	logic rdCnt;
	logic rdEvt;
	assign hitPage = (regAddr[15:12] == PORT_NUM);
	assign wrDiag  = regWr && hitPage && (regAddr[11:0] == OFS_CABLE_DIAG);
	assign wrEvt   = regWr && hitPage && (regAddr[11:0] == OFS_EVENT_CTRL);
	assign rdCnt   = regRd && hitPage && (regAddr[11:0] == OFS_RX_SYM_ERR);
	assign rdEvt   = regRd && hitPage && (regAddr[11:0] == OFS_EVENT_CTRL);
	// =========================================================
	// cable diagnostic
	pdsir_diag_t diagState_ff;
	pdsir_diag_t nxt_diagState;
	logic [1:0]  pairSel_ff;
	logic [1:0]  nxt_pairSel;
	logic [2:0]  rsvBits_ff;
	logic [2:0]  nxt_rsvBits;
	logic [1:0]  result_ff;
	logic [1:0]  nxt_result;
	logic        start_ff;
	logic        nxt_start;
	logic        running;
	assign running = (diagState_ff == DIAG_RUN);
	always_comb
	begin
		nxt_diagState = diagState_ff;
		nxt_pairSel   = pairSel_ff;
		nxt_rsvBits   = rsvBits_ff;
		nxt_result    = result_ff;
		nxt_start     = 1'b0;
		case (diagState_ff)
			DIAG_IDLE:
			begin
				if (wrDiag)
				begin
					nxt_pairSel = regWdata[DIAG_PAIR_LSB +: 2]; // [R4]
					nxt_rsvBits = {regWdata[DIAG_RSV14_BIT],
						regWdata[DIAG_RSV_LSB +: 2]};
					if (regWdata[DIAG_TRIG_BIT]) // [R1] [R2]
					begin
						nxt_diagState = DIAG_RUN;
						nxt_start     = 1'b1;
					end
				end
			end
			DIAG_RUN:
			begin
				// pair stays fixed while the measurement runs
				if (diagDone)
				begin
					nxt_result    = diagResult; // [R5]
					nxt_diagState = DIAG_IDLE; // [R1]
				end
			end
			default:
				nxt_diagState = DIAG_IDLE;
		endcase
	end
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			diagState_ff <= DIAG_IDLE;
			pairSel_ff   <= PAIR_RESET;
			rsvBits_ff   <= 3'h0;
			result_ff    <= RESULT_RESET;
			start_ff     <= 1'b0;
		end
		else
		begin
			diagState_ff <= nxt_diagState;
			pairSel_ff   <= nxt_pairSel;
			rsvBits_ff   <= nxt_rsvBits;
			result_ff    <= nxt_result;
			start_ff     <= nxt_start;
		end
	end
	assign diagStart = start_ff;
	assign diagPair  = pairSel_ff;
	// =========================================================
	// symbol error frame counter and event flags
	logic [15:0] errCount_ff;
	logic [15:0] nxt_errCount;
	logic [7:0]  evtEn_ff;
	logic [7:0]  nxt_evtEn;
	logic [7:0]  evtFlag_ff;
	logic [7:0]  nxt_evtFlag;
	always_comb
	begin
		nxt_errCount = errCount_ff;
		if (rdCnt) // [R8]
			nxt_errCount = COUNT_RESET;
		// a frame arriving in the read cycle is kept in the fresh count
		if (symErrFrame && (nxt_errCount != COUNT_MAX))
			nxt_errCount = nxt_errCount + 16'h0001; // [R8]
		nxt_evtEn = evtEn_ff;
		if (wrEvt)
			nxt_evtEn = regWdata[EVENT_EN_LSB +: 8]; // [R9]
		// events set flags regardless of enable; set wins over read clear
		nxt_evtFlag = rdEvt ? EVENT_RESET : evtFlag_ff; // [R11]
		nxt_evtFlag = nxt_evtFlag | eventIn; // [R11] [R14]
	end
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			errCount_ff <= COUNT_RESET;
			evtEn_ff    <= EVENT_RESET; // [R12]
			evtFlag_ff  <= EVENT_RESET; // [R12]
		end
		else
		begin
			errCount_ff <= nxt_errCount;
			evtEn_ff    <= nxt_evtEn;
			evtFlag_ff  <= nxt_evtFlag;
		end
	end
	assign irqReq = |(evtEn_ff & evtFlag_ff); // [R13]
	// =========================================================
	// read mux
	logic [15:0] rdata_ff;
	logic [15:0] nxt_rdata;
	logic        rdValid_ff;
	logic        nxt_rdValid;
	always_comb
	begin
		nxt_rdata   = 16'h0000;
		nxt_rdValid = regRd;
		if (regRd && hitPage)
		begin
			case (regAddr[11:0])
				OFS_CABLE_DIAG:
				begin
					nxt_rdata[DIAG_TRIG_BIT]         = running; // [R3]
					nxt_rdata[DIAG_RSV14_BIT]        = rsvBits_ff[2];
					nxt_rdata[DIAG_PAIR_LSB +: 2]    = pairSel_ff; // [R4]
					nxt_rdata[DIAG_RSV_LSB +: 2]     = rsvBits_ff[1:0];
					nxt_rdata[DIAG_RESULT_LSB +: 2]  = result_ff; // [R5]
				end
				OFS_LINK_STATUS:
				begin
					nxt_rdata[LINK_GIG_BIT]  = gigLinkUp; // [R6]
					nxt_rdata[LINK_FAST_BIT] = fastLinkUp; // [R7]
				end
				OFS_RX_SYM_ERR:
					nxt_rdata = errCount_ff; // [R8]
				OFS_EVENT_CTRL:
					nxt_rdata = {evtEn_ff, evtFlag_ff}; // [R9] [R10]
				default:
					nxt_rdata = 16'h0000;
			endcase
		end
	end
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			rdata_ff   <= 16'h0000;
			rdValid_ff <= 1'b0;
		end
		else
		begin
			rdata_ff   <= nxt_rdata;
			rdValid_ff <= nxt_rdValid;
		end
	end
	assign regRdata   = rdata_ff;
	assign regRdValid = rdValid_ff;
	// =========================================================
	// checks
	sequence s_trigWrite;
		wrDiag && regWdata[DIAG_TRIG_BIT] && !running;
	endsequence
	sequence s_testEnd;
		running && diagDone;
	endsequence
	property p_start;
		@(posedge clock) disable iff (rst)
		s_trigWrite |=> diagStart && running
			&& diagPair == $past(regWdata[DIAG_PAIR_LSB +: 2]);
	endproperty
	a_start: assert property (p_start) // [R1] [R4]
		else $error("test did not start");
	property p_selfClear;
		@(posedge clock) disable iff (rst)
		s_testEnd |=> !running && result_ff == $past(diagResult);
	endproperty
	a_selfClear: assert property (p_selfClear) // [R1] [R5]
		else $error("no self clear");
	property p_noStart;
		@(posedge clock) disable iff (rst)
		wrDiag && !regWdata[DIAG_TRIG_BIT] && !running
			|=> !running && !diagStart;
	endproperty
	a_noStart: assert property (p_noStart) // [R2]
		else $error("zero write started");
	property p_readBusy;
		@(posedge clock) disable iff (rst)
		regRd && hitPage && regAddr[11:0] == OFS_CABLE_DIAG
			|=> regRdValid && regRdata[DIAG_TRIG_BIT] == $past(running);
	endproperty
	a_readBusy: assert property (p_readBusy) // [R3]
		else $error("busy bit wrong");
	property p_linkRead;
		@(posedge clock) disable iff (rst)
		regRd && hitPage && regAddr[11:0] == OFS_LINK_STATUS
			|=> regRdata == {14'h0000, $past(gigLinkUp), $past(fastLinkUp)};
	endproperty
	a_linkRead: assert property (p_linkRead) // [R6] [R7]
		else $error("link bits wrong");
	property p_cntClear;
		@(posedge clock) disable iff (rst)
		rdCnt && !symErrFrame |=> errCount_ff == COUNT_RESET
			##1 (errCount_ff == COUNT_RESET || $past(symErrFrame));
	endproperty
	a_cntClear: assert property (p_cntClear) // [R8]
		else $error("count not cleared");
	property p_enWrite;
		@(posedge clock) disable iff (rst)
		wrEvt |=> evtEn_ff == $past(regWdata[EVENT_EN_LSB +: 8]);
	endproperty
	a_enWrite: assert property (p_enWrite) // [R9]
		else $error("enable not stored");
	property p_flagSet;
		@(posedge clock) disable iff (rst)
		eventIn != 8'h00 |=> (evtFlag_ff & $past(eventIn)) == $past(eventIn)
			&& regRdValid == $past(regRd);
	endproperty
	a_flagSet: assert property (p_flagSet) // [R11] [R14]
		else $error("event lost");
	property p_flagClear;
		@(posedge clock) disable iff (rst)
		rdEvt && eventIn == 8'h00 |=> evtFlag_ff == 8'h00 && !irqReq
			&& regRdata[7:0] == $past(evtFlag_ff);
	endproperty
	a_flagClear: assert property (p_flagClear) // [R10] [R11] [R13]
		else $error("flags not cleared");
	property p_irqRaise;
		@(posedge clock) disable iff (rst)
		(eventIn & evtEn_ff) != 8'h00 && !wrEvt |=> irqReq;
	endproperty
	a_irqRaise: assert property (p_irqRaise) // [R13]
		else $error("irq missing");
	property p_resetState;
		@(posedge clock)
		$fell(rst) |-> evtEn_ff == 8'h00 && evtFlag_ff == 8'h00
			&& pairSel_ff == PAIR_RESET && !irqReq;
	endproperty
	a_resetState: assert property (p_resetState) // [R12] [R4]
		else $error("bad reset");
endmodule
`default_nettype wire

/* File: bench/pdsir_port_regs_test.sv */
// Purpose: self-checking bench for one port's diagnostic and event registers
// Assumes: the bench owns every input; strobes change on the falling edge
// Notes: random values come from an lfsr with a fixed start value
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; \
	$display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module pdsir_port_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	import pdsir_pkg::*;
	// =========================================================
	// signals
	localparam logic [3:0] PN = 4'h2;
	logic        clock, rst, regWr, regRd, diagDone, gigLinkUp, fastLinkUp;
	logic        symErrFrame, regRdValid, diagStart, irqReq;
	logic [15:0] regAddr, regWdata, regRdata, rv;
	logic [1:0]  diagResult, diagPair, p;
	logic [7:0]  eventIn, en, ev;
	logic [31:0] seed;
	int          err_count, checks_done, n;
	pdsir_port_regs #(.PORT_NUM(PN)) DUT
	(
		.clock(clock), .rst(rst), .regAddr(regAddr), .regWr(regWr),
		.regRd(regRd), .regWdata(regWdata), .regRdata(regRdata),
		.regRdValid(regRdValid), .diagStart(diagStart), .diagPair(diagPair),
		.diagDone(diagDone), .diagResult(diagResult), .gigLinkUp(gigLinkUp),
		.fastLinkUp(fastLinkUp), .symErrFrame(symErrFrame),
		.eventIn(eventIn), .irqReq(irqReq)
	);
	always #10 clock = ~clock;
	// =========================================================
	// helpers
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] diag_exp(input logic [1:0] pr,
		input logic [1:0] r);
		return {2'h0, pr, 2'h0, r, 8'h00};
	endfunction
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clock);
		regWr = 1'b1;
		regAddr = a;
		regWdata = d;
		@(negedge clock);
		regWr = 1'b0;
	endtask
	// read data is taken in the cycle the valid pulse stands
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(negedge clock);
		regRd = 1'b1;
		regAddr = a;
		@(negedge clock);
		regRd = 1'b0;
		`CHK(regRdValid, 1'b1)
		d = regRdata;
	endtask
	task automatic ev_pulse(input logic [7:0] v);
		@(negedge clock);
		eventIn = v;
		@(negedge clock);
		eventIn = 8'h00;
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// =========================================================
	// watchdog
	initial
	begin
		repeat (20000) @(posedge clock);
		err_count++;
		complete_run;
	end
	// =========================================================
	// tests
	initial
	begin
		clock = 0; rst = 1; regWr = 0; regRd = 0; regAddr = 16'h0000;
		regWdata = 16'h0000; diagDone = 0; diagResult = 2'h0; gigLinkUp = 0;
		fastLinkUp = 0; symErrFrame = 0; eventIn = 8'h00; seed = 32'hD634;
		err_count = 0; checks_done = 0;
		repeat (20) @(posedge clock);
		@(negedge clock);
		rst = 0;
		rd({PN, OFS_CABLE_DIAG}, rv);
		`CHK(rv, 16'h0000)
		rd({PN, OFS_RX_SYM_ERR}, rv);
		`CHK(rv, 16'h0000)
		rd({PN, OFS_EVENT_CTRL}, rv);
		`CHK(rv, 16'h0000)
		`CHK(diagPair, 2'h0)
		rd({PN ^ 4'h3, OFS_EVENT_CTRL}, rv);
		`CHK(rv, 16'h0000)
		$display("reset values done");
		for (int i = 0; i < 6; i++)
		begin
			seed = nxt(seed);
			@(negedge clock);
			{gigLinkUp, fastLinkUp} = seed[1:0];
			rd({PN, OFS_LINK_STATUS}, rv);
			`CHK(rv, {14'h0, seed[1:0]})
		end
		$display("link status done");
		for (int r = 0; r < 3; r++)
		begin
			seed = nxt(seed);
			p = seed[1:0];
			wr({PN, OFS_CABLE_DIAG}, {2'h2, p, 12'h000});
			`CHK(diagStart, 1'b1)
			`CHK(diagPair, p)
			@(negedge clock);
			`CHK(diagStart, 1'b0)
			wr({PN, OFS_CABLE_DIAG}, {2'h0, ~p, 12'h000});
			rd({PN, OFS_CABLE_DIAG}, rv);
			`CHK(rv[15], 1'b1)
			`CHK(diagPair, p)
			repeat (seed[4:2]) @(negedge clock);
			diagDone = 1'b1;
			diagResult = r[1:0];
			@(negedge clock);
			diagDone = 1'b0;
			rd({PN, OFS_CABLE_DIAG}, rv);
			`CHK(rv, diag_exp(p, r[1:0]))
			wr({PN, OFS_CABLE_DIAG}, {2'h0, p, 12'h000});
			`CHK(diagStart, 1'b0)
			rd({PN, OFS_CABLE_DIAG}, rv);
			`CHK(rv, diag_exp(p, r[1:0]))
		end
		$display("cable diagnostic done");
		for (int i = 0; i < 3; i++)
		begin
			seed = nxt(seed);
			n = 1 + seed[4:0];
			repeat (n)
			begin
				@(negedge clock);
				symErrFrame = 1'b1;
			end
			@(negedge clock);
			symErrFrame = 1'b0;
			rd({PN, OFS_RX_SYM_ERR}, rv);
			`CHK(rv, n[15:0])
			rd({PN, OFS_RX_SYM_ERR}, rv);
			`CHK(rv, 16'h0000)
		end
		$display("error counter done");
		for (int i = 0; i < 6; i++)
		begin
			seed = nxt(seed);
			en = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : seed[7:0];
			ev = (i == 0) ? 8'hFF : (i == 1) ? 8'h01 : seed[15:8];
			wr({PN, OFS_EVENT_CTRL}, {en, 8'hFF});
			rd({PN, OFS_EVENT_CTRL}, rv);
			`CHK(rv, {en, 8'h00})
			ev_pulse(ev);
			`CHK(irqReq, |(en & ev))
			repeat (2) @(negedge clock);
			`CHK(irqReq, |(en & ev))
			rd({PN, OFS_EVENT_CTRL}, rv);
			`CHK(rv, {en, ev})
			`CHK(irqReq, 1'b0)
			rd({PN, OFS_EVENT_CTRL}, rv);
			`CHK(rv, {en, 8'h00})
		end
		$display("event flags done");
		// an event or an error frame in the very cycle of the clearing read
		@(negedge clock);
		regRd = 1'b1;
		regAddr = {PN, OFS_EVENT_CTRL};
		eventIn = 8'h24;
		@(negedge clock);
		regRd = 1'b0;
		eventIn = 8'h00;
		rd({PN, OFS_EVENT_CTRL}, rv);
		`CHK(rv[7:0], 8'h24)
		@(negedge clock);
		regRd = 1'b1;
		regAddr = {PN, OFS_RX_SYM_ERR};
		symErrFrame = 1'b1;
		@(negedge clock);
		regRd = 1'b0;
		symErrFrame = 1'b0;
		rd({PN, OFS_RX_SYM_ERR}, rv);
		`CHK(rv, 16'h0001)
		// second reset with enables, two flags and a pair set
		wr({PN, OFS_EVENT_CTRL}, 16'hFF00);
		wr({PN, OFS_CABLE_DIAG}, 16'h3000);
		ev_pulse(8'h81);
		`CHK(irqReq, 1'b1)
		`CHK(diagPair, 2'h3)
		@(negedge clock);
		rst = 1'b1;
		repeat (3) @(negedge clock);
		rst = 1'b0;
		`CHK(irqReq, 1'b0)
		`CHK(diagPair, 2'h0)
		rd({PN, OFS_EVENT_CTRL}, rv);
		`CHK(rv, 16'h0000)
		$display("corners and second reset done");
		complete_run;
	end
endmodule
`undef CHK
`default_nettype wire
